/* gms_axil.sv */
// AXI4-Lite slave front end for the register bank
`timescale 1ns/100ps
module gms_axil import gms_pkg::*; (
  input  wire logic              sys_clk,  // core clock
  input  wire logic              rst,      // sync reset, high
  input  wire logic [ADDR_W-1:0] awaddr,   // write address
  input  wire logic              awvalid,  // write address valid
  output logic                   awready,  // write address ready
  input  wire logic [31:0]       wdata,    // write data
  input  wire logic [3:0]        wstrb,    // byte enables
  input  wire logic              wvalid,   // write data valid
  output logic                   wready,   // write data ready
  output logic [1:0]             bresp,    // write response
  output logic                   bvalid,   // write response valid
  input  wire logic              bready,   // write response ready
  input  wire logic [ADDR_W-1:0] araddr,   // read address
  input  wire logic              arvalid,  // read address valid
  output logic                   arready,  // read address ready
  output logic [31:0]            rdata,    // read data
  output logic [1:0]             rresp,    // read response
  output logic                   rvalid,   // read data valid
  input  wire logic              rready,   // read data ready
  output logic                   wr_en,    // write strobe
  output logic [ADDR_W-1:0]      wr_addr,  // write address
  output logic [31:0]            wr_data,  // write data
  output logic [3:0]             wr_strb,  // write lanes
  input  wire logic              wr_ok,    // address mapped
  output logic                   rd_en,    // read strobe
  input  wire logic [15:0]       rd_data,  // read word
  input  wire logic              rd_ok     // address mapped
);
  typedef struct packed {
    logic              aw_have;
    logic              w_have;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [15:0]       rdata;
  } gms_axil_st_type;
  gms_axil_st_type s_q, s_d;
  assign awready = !s_q.aw_have;
  assign wready  = !s_q.w_have;
  assign arready = !s_q.rvalid;
  // One write at a time: the next waits for the response to go
  assign wr_en   = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign rd_en   = arvalid && !s_q.rvalid;
  assign wr_addr = s_q.addr;
  assign wr_data = s_q.data;
  assign wr_strb = s_q.strb;
  always_comb begin
    s_d = s_q;
    if (awvalid && !s_q.aw_have) begin
      s_d.aw_have = 1'b1;
      s_d.addr    = awaddr;
    end
    if (wvalid && !s_q.w_have) begin
      s_d.w_have = 1'b1;
      s_d.data   = wdata;
      s_d.strb   = wstrb;
    end
    if (s_q.bvalid && bready) s_d.bvalid = 1'b0;
    if (wr_en) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.rvalid && rready) s_d.rvalid = 1'b0;
    if (rd_en) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      s_d.rdata  = rd_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign bvalid = s_q.bvalid;
  assign bresp  = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rresp  = s_q.rresp;
  assign rdata  = {16'h0000, s_q.rdata};
endmodule

/* gms_idle_cnt.sv */
// Saturating idle-error counter with overflow event
`timescale 1ns/100ps
module gms_idle_cnt import gms_pkg::*; #(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             sys_clk,  // core clock
  input  wire logic             rst,      // sync reset, high
  input  wire logic             clr,      // read or reset clear
  input  wire logic             err,      // idle error seen
  output logic      [CNT_W-1:0] count,    // current count
  output logic                  ovf       // pulse on reaching max
);
  initial begin
    if (CNT_W < 1 || CNT_W > 8) $error("CNT_W must be 1..8");
  end
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             ovf;
  } gms_cnt_st_type;
  gms_cnt_st_type s_q, s_d;
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  always_comb begin
    s_d = s_q;
    s_d.ovf = 1'b0;
    // An error in the clearing cycle is counted, not lost
    if (clr) begin
      s_d.cnt = err ? CNT_W'(1) : IDLE_CNT_RESET[CNT_W-1:0];
    end else if (err && s_q.cnt != CNT_MAX) begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
      s_d.ovf = (s_q.cnt == CNT_MAX - CNT_W'(1));
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign count = s_q.cnt;
  assign ovf   = s_q.ovf;
endmodule

/* gms_pkg.sv */
// Constants and types of the gigabit role register bank
package gms_pkg;
  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [5:0] IDX_ROLE_CTRL = 6'h09;
  localparam logic [5:0] IDX_ROLE_STAT = 6'h0A;
  localparam logic [5:0] IDX_EXT_ABIL  = 6'h0F;
  localparam logic [5:0] IDX_LOGIC_RST = 6'h10;
  localparam logic [1:0] WORD_LSB      = 2'h0;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_TEST_LO = 13;
  localparam int unsigned CTRL_MAN_EN  = 12;
  localparam int unsigned CTRL_MAN_VAL = 11;
  localparam int unsigned CTRL_PORT    = 10;
  localparam int unsigned CTRL_ADV_FD  = 9;
  localparam int unsigned CTRL_ADV_HD  = 8;
  localparam int unsigned STAT_FAULT   = 15;
  localparam int unsigned STAT_ROLE    = 14;
  localparam int unsigned STAT_LRX     = 13;
  localparam int unsigned STAT_RRX     = 12;
  localparam int unsigned STAT_LP_FD   = 11;
  localparam int unsigned STAT_LP_HD   = 10;
  localparam int unsigned LOGIC_RESET_BIT_BIT     = 0;
  localparam int unsigned HI_LANE      = 1;
  localparam int unsigned LO_LANE      = 0;
  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [15:0] EXT_ABIL_VALUE = 16'h3000;
  localparam logic [7:0]  IDLE_CNT_RESET = 8'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  typedef enum logic [2:0] {
    TM_NORMAL     = 3'h0,
    TM_WAVEFORM   = 3'h1,
    TM_JIT_MASTER = 3'h2,
    TM_JIT_SLAVE  = 3'h3,
    TM_DISTORT    = 3'h4
  } gms_test_mode_type;
endpackage

/* gms_regs.sv */
// Gigabit master/slave control, status and extended ability registers
//
// What this block does
// - Control bits 15:13 select normal or one of four transmit tests.
// - Control bit 12 set: manual role used, else automatic resolution.
// - Control bit 11 forces master(1) or slave(0), only when bit 12 set.
// - Control bit 10 declares multiport, only with manual role off.
// - Control bits 9 and 8 advertise gigabit full and half duplex.
// - Control bits 12:8 reset to values from the mode strap pins.
// - Status bit 15 latches a role configuration fault, resets to 0.
// - Status bit 14 reports resolved role, 1 master.
// - Status bits 13 and 12 report local and remote receiver OK.
// - Status bits 11 and 10 give partner gigabit abilities, page-qualified.
// - Status bits 7:0 count idle-symbol errors, reset 00h.
// - Idle count clears on status read and on every kind of reset.
// - Idle count saturates at all ones.
// - Idle count overflow is offered as an interrupt source.
// - Extended ability reads gigabit-T full and half set, X clear.
// - Page-received latches high on a new partner page.
// - Writing 1 to the logic reset bit makes a synchronous logic reset.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
module gms_regs import gms_pkg::*; #(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic              sys_clk,        // 40 MHz core clock
  input  wire logic              rst,            // sync reset, high
  input  wire logic              sw_reset,       // software reset pulse
  input  wire logic [4:0]        strap_ctrl,     // strap defaults 12:8
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // write address
  input  wire logic              s_axi_awvalid,  // write address valid
  output logic                   s_axi_awready,  // write address ready
  input  wire logic [31:0]       s_axi_wdata,    // write data
  input  wire logic [3:0]        s_axi_wstrb,    // byte enables
  input  wire logic              s_axi_wvalid,   // write data valid
  output logic                   s_axi_wready,   // write data ready
  output logic [1:0]             s_axi_bresp,    // write response
  output logic                   s_axi_bvalid,   // response valid
  input  wire logic              s_axi_bready,   // response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,   // read address
  input  wire logic              s_axi_arvalid,  // read address valid
  output logic                   s_axi_arready,  // read address ready
  output logic [31:0]            s_axi_rdata,    // read data
  output logic [1:0]             s_axi_rresp,    // read response
  output logic                   s_axi_rvalid,   // read data valid
  input  wire logic              s_axi_rready,   // read data ready
  input  wire logic              cfg_fault,      // role fault present
  input  wire logic              resolved_master,// resolved role
  input  wire logic              local_rx_ok,    // local receiver OK
  input  wire logic              remote_rx_ok,   // remote receiver OK
  input  wire logic              new_page,       // partner page pulse
  input  wire logic              an_restart,     // negotiation restart
  input  wire logic              partner_gig_full_duplex_ability, // LP
  input  wire logic              partner_gig_half_duplex_ability, // LP
  input  wire logic              idle_err,       // idle error pulse
  output gms_test_mode_type      test_mode,      // active test mode
  output logic                   manual_role,    // manual role in use
  output logic                   forced_master,  // forced master
  output logic                   multiport,      // multiport for auto
  output logic                   adv_gig_fd,     // advertise 1000 FD
  output logic                   adv_gig_hd,     // advertise 1000 HD
  output logic                   page_received,  // page-received flag
  output logic                   logic_reset,    // logic reset pulse
  output logic                   idle_ovf_evt    // overflow event
);
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  initial begin
    if (CNT_W < 1 || CNT_W > 8) $error("CNT_W must be 1..8");
  end

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [5:0] i;
    i = idx_of(a);
    return (a[1:0] == WORD_LSB) &&
           (i == IDX_ROLE_CTRL || i == IDX_ROLE_STAT ||
            i == IDX_EXT_ABIL  || i == IDX_LOGIC_RST);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] test;
    logic       man_en;
    logic       man_val;
    logic       port;
    logic       adv_fd;
    logic       adv_hd;
    logic       fault;
    logic       page;
    logic       logic_reset_bit;
  } gms_regs_st_type;
  gms_regs_st_type s_q, s_d;

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              rd_en;
  logic [15:0]       rd_word;
  logic [15:0]       stat_word;
  logic [15:0]       ctrl_word;
  logic              rd_stat;
  logic              cnt_clr;
  logic [CNT_W-1:0]  idle_cnt;
  logic              cnt_ovf;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  gms_axil u_axil (
    .sys_clk (sys_clk),
    .rst     (rst),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (mapped(wr_addr)),
    .rd_en   (rd_en),
    .rd_data (rd_word),
    .rd_ok   (mapped(s_axi_araddr))
  );

  // ----------------------------------------------------------------
  // Idle error counter
  // ----------------------------------------------------------------
  assign rd_stat = rd_en && mapped(s_axi_araddr) &&
                   idx_of(s_axi_araddr) == IDX_ROLE_STAT;
  assign cnt_clr = rd_stat || sw_reset || s_q.logic_reset_bit;

  gms_idle_cnt #(
    .CNT_W (CNT_W)
  ) u_cnt (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clr     (cnt_clr),
    .err     (idle_err),
    .count   (idle_cnt),
    .ovf     (cnt_ovf)
  );
  assign idle_ovf_evt = cnt_ovf;

  // ----------------------------------------------------------------
  // Read words
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_word = '0;
    ctrl_word[15:CTRL_TEST_LO] = s_q.test;
    ctrl_word[CTRL_MAN_EN]  = s_q.man_en;
    ctrl_word[CTRL_MAN_VAL] = s_q.man_val;
    ctrl_word[CTRL_PORT]    = s_q.port;
    ctrl_word[CTRL_ADV_FD]  = s_q.adv_fd;
    ctrl_word[CTRL_ADV_HD]  = s_q.adv_hd;
    stat_word = '0;
    stat_word[STAT_FAULT] = s_q.fault;
    stat_word[STAT_ROLE]  = resolved_master;
    stat_word[STAT_LRX]   = local_rx_ok;
    stat_word[STAT_RRX]   = remote_rx_ok;
    // partner bits only once page seen
    stat_word[STAT_LP_FD] = s_q.page && partner_gig_full_duplex_ability;
    stat_word[STAT_LP_HD] = s_q.page && partner_gig_half_duplex_ability;
    stat_word[CNT_W-1:0]  = idle_cnt;
  end

  // unlisted bits and addresses read zero
  always_comb begin
    rd_word = '0;
    if (mapped(s_axi_araddr)) begin
      unique case (idx_of(s_axi_araddr))
        IDX_ROLE_CTRL: rd_word = ctrl_word;
        IDX_ROLE_STAT: rd_word = stat_word;
        IDX_EXT_ABIL:  rd_word = EXT_ABIL_VALUE;
        default:       rd_word = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.logic_reset_bit = 1'b0;
    if (wr_en && mapped(wr_addr)) begin
      // writes land only in defined fields
      if (idx_of(wr_addr) == IDX_ROLE_CTRL && wr_strb[HI_LANE]) begin
        s_d.test    = wr_data[15:CTRL_TEST_LO];
        s_d.man_en  = wr_data[CTRL_MAN_EN];
        s_d.man_val = wr_data[CTRL_MAN_VAL];
        s_d.port    = wr_data[CTRL_PORT];
        s_d.adv_fd  = wr_data[CTRL_ADV_FD];
        s_d.adv_hd  = wr_data[CTRL_ADV_HD];
      end
      if (idx_of(wr_addr) == IDX_LOGIC_RST && wr_strb[LO_LANE]) begin
        s_d.logic_reset_bit = wr_data[LOGIC_RESET_BIT_BIT];
      end
    end
    // hold until read; a live fault wins over the clear
    s_d.fault = cfg_fault || (s_q.fault && !rd_stat);
    // latch on new page; new page wins over restart
    s_d.page = new_page || (s_q.page && !an_restart);
    // Logic reset leaves register sets alone, clears latched flags
    if (s_q.logic_reset_bit) begin
      s_d.fault = cfg_fault;
      s_d.page  = new_page;
    end
    if (sw_reset) begin
      {s_d.man_en, s_d.man_val, s_d.port, s_d.adv_fd, s_d.adv_hd} =
        strap_ctrl;
      s_d.test  = TM_NORMAL;
      s_d.fault = cfg_fault;
      s_d.page  = new_page;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
      // straps sampled on the clocked reset
      {s_q.man_en, s_q.man_val, s_q.port, s_q.adv_fd, s_q.adv_hd} <=
        strap_ctrl;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the transceiver core
  // ----------------------------------------------------------------
  // reserved codes run as normal mode
  assign test_mode = (s_q.test > TM_DISTORT) ? TM_NORMAL
                     : gms_test_mode_type'(s_q.test);
  assign manual_role   = s_q.man_en;
  assign forced_master = s_q.man_en && s_q.man_val;
  assign multiport     = !s_q.man_en && s_q.port;
  assign adv_gig_fd    = s_q.adv_fd;
  assign adv_gig_hd    = s_q.adv_hd;
  assign page_received = s_q.page;
  assign logic_reset   = s_q.logic_reset_bit;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic ctrl_wr;
  logic logic_reset_bit_wr;
  assign ctrl_wr = wr_en && mapped(wr_addr) && wr_strb[HI_LANE] &&
                   idx_of(wr_addr) == IDX_ROLE_CTRL;
  assign logic_reset_bit_wr = wr_en && mapped(wr_addr) && wr_strb[LO_LANE] &&
                   idx_of(wr_addr) == IDX_LOGIC_RST &&
                   wr_data[LOGIC_RESET_BIT_BIT];

  sequence logic_reset_bit_req;
    logic_reset_bit_wr && !sw_reset;
  endsequence
  // An idle error in the pulse cycle is counted after the clear
  sequence logic_reset_bit_done;
    logic_reset ##1 idle_cnt == CNT_W'($past(idle_err));
  endsequence

  a_ctrl_write:
    assert property (ctrl_wr && !sw_reset |=>
                     s_q.test == $past(wr_data[15:CTRL_TEST_LO]))
    else $error("test field not written");

  a_test_legal:
    assert property (s_q.test > TM_DISTORT |-> test_mode == TM_NORMAL)
    else $error("reserved test code reached the core");

  a_forced_role:
    assert property (!manual_role |-> !forced_master)
    else $error("forced master without manual enable");

  a_port_type:
    assert property (manual_role |-> !multiport)
    else $error("port type used under manual role");

  a_strap_load:
    assert property ($fell(rst) |->
      ctrl_word[CTRL_MAN_EN:CTRL_ADV_HD] == $past(strap_ctrl))
    else $error("strap defaults not loaded");

  a_fault_hold:
    assert property (s_q.fault && !rd_stat && !s_q.logic_reset_bit && !sw_reset
                     |=> s_q.fault)
    else $error("fault flag dropped before read");

  a_fault_read:
    assert property (rd_stat && !cfg_fault ##1 !cfg_fault
                     |-> !s_q.fault)
    else $error("fault flag not cleared by read");

  a_lp_qualify:
    assert property (!page_received |->
                     stat_word[STAT_LP_FD:STAT_LP_HD] == 2'b00)
    else $error("partner ability shown without page");

  a_cnt_read:
    assert property (rd_stat && !idle_err |=> idle_cnt == '0)
    else $error("idle count not cleared by read");

  a_cnt_sat:
    assert property (idle_cnt == '1 && !cnt_clr |=> idle_cnt == '1)
    else $error("idle count wrapped");

  a_ovf_event:
    assert property (idle_ovf_evt |-> idle_cnt == '1 ##1 !idle_ovf_evt)
    else $error("overflow event not at saturation");

  a_logic_reset_bit_clear:
    assert property (logic_reset_bit_req |=> logic_reset_bit_done)
    else $error("logic reset did not clear counter");

endmodule

/* test_gms_regs.sv */
// Self-checking testbench of the gigabit role register bank
`timescale 1ns/100ps
module test_gms_regs import gms_pkg::*;;
  logic              sys_clk, rst, sw_reset, idle_err, cfg_fault;
  logic              resolved_master, local_rx_ok, remote_rx_ok;
  logic              new_page, an_restart;
  logic              partner_gig_full_duplex_ability;
  logic              partner_gig_half_duplex_ability;
  logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_rready, s_axi_awready;
  logic              s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic              s_axi_rvalid, manual_role, forced_master;
  logic              multiport, adv_gig_fd, adv_gig_hd;
  logic              page_received, logic_reset, idle_ovf_evt;
  logic [4:0]        strap_ctrl;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [31:0]       s_axi_wdata, s_axi_rdata, d;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [15:0]       m_ctrl;
  gms_test_mode_type test_mode;
  int                m_cnt, error_cnt, comparisons, ovf_n, lr_n;
  bit                m_fault, m_page;

  gms_regs u_dut (.sys_clk, .rst, .sw_reset, .strap_ctrl, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_fault,
    .resolved_master, .local_rx_ok, .remote_rx_ok, .new_page, .an_restart,
    .partner_gig_full_duplex_ability, .partner_gig_half_duplex_ability,
    .idle_err, .test_mode, .manual_role, .forced_master, .multiport,
    .adv_gig_fd, .adv_gig_hd, .page_received, .logic_reset,
    .idle_ovf_evt);

  always #12.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    ovf_n += (idle_ovf_evt === 1'h1);
    lr_n += (logic_reset === 1'h1);
  end

  // ----------------------------------------------------------------
  // Compare, bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk({30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(e, s_axi_rdata);
    chk({30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  // Status read clears count and fault, so the model follows it
  task automatic rd_stat();
    rd(8'h28, {16'h0, m_fault, resolved_master, local_rx_ok, remote_rx_ok,
       m_page & partner_gig_full_duplex_ability,
       m_page & partner_gig_half_duplex_ability, 2'h0, 8'(m_cnt)},
       RESP_OKAY);
    m_cnt = 0;
    m_fault = cfg_fault;
  endtask

  task automatic idle(input int n);
    @(posedge sys_clk);
    idle_err <= 1'h1;
    repeat (n) @(posedge sys_clk);
    idle_err <= 1'h0;
    m_cnt = (m_cnt + n > 255) ? 255 : m_cnt + n;
  endtask

  task automatic end_of_test();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(71));
    {sys_clk, sw_reset, idle_err, cfg_fault, new_page, an_restart} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {partner_gig_full_duplex_ability, partner_gig_half_duplex_ability} =
      2'($urandom);
    {resolved_master, local_rx_ok, remote_rx_ok, strap_ctrl} = 8'($urandom);
    {s_axi_wdata, s_axi_wstrb, rst} = {32'h0, 4'hF, 1'h1};
    repeat (20) @(posedge sys_clk);
    rst <= 1'h0;
    m_ctrl = {3'h0, strap_ctrl, 8'h00};
    rd(8'h24, {16'h0, m_ctrl}, RESP_OKAY);
    rd_stat();
    wr(8'h3C, 32'hFFFFFFFF, RESP_OKAY);
    rd(8'h3C, 32'h00003000, RESP_OKAY);
    rd(8'h44, 32'h0, RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d[15:13] = 3'(i);
      wr(8'h24, d, RESP_OKAY);
      m_ctrl = d[15:0] & 16'hFF00;
      rd(8'h24, {16'h0, m_ctrl}, RESP_OKAY);
      chk((i < 5) ? 32'(i) : 32'h0, {29'h0, test_mode});
      chk({27'h0, m_ctrl[12], m_ctrl[12] & m_ctrl[11],
           !m_ctrl[12] & m_ctrl[10], m_ctrl[9:8]},
          {27'h0, manual_role, forced_master, multiport,
           adv_gig_fd, adv_gig_hd});
    end
    // Upper lane off: the control write must be ignored
    s_axi_wstrb <= 4'h1;
    wr(8'h24, 32'h0000FF00, RESP_OKAY);
    rd(8'h24, {16'h0, m_ctrl}, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    @(posedge sys_clk);
    sw_reset <= 1'h1;
    @(posedge sys_clk);
    sw_reset <= 1'h0;
    m_ctrl = {3'h0, strap_ctrl, 8'h00};
    rd(8'h24, {16'h0, m_ctrl}, RESP_OKAY);
    idle(5);
    rd_stat();
    rd_stat();
    idle(300);
    rd_stat();
    chk(32'h1, 32'(ovf_n));
    @(posedge sys_clk);
    cfg_fault <= 1'h1;
    @(posedge sys_clk);
    cfg_fault <= 1'h0;
    m_fault = 1'b1;
    rd_stat();
    rd_stat();
    @(posedge sys_clk);
    new_page <= 1'h1;
    @(posedge sys_clk);
    new_page <= 1'h0;
    m_page = 1'b1;
    rd_stat();
    chk(32'h1, {31'h0, page_received});
    @(posedge sys_clk);
    an_restart <= 1'h1;
    @(posedge sys_clk);
    an_restart <= 1'h0;
    new_page <= 1'h1;
    {resolved_master, local_rx_ok, remote_rx_ok} <= 3'($urandom);
    @(posedge sys_clk);
    new_page <= 1'h0;
    chk(32'h0, {31'h0, page_received});
    idle(3);
    wr(8'h40, 32'h1, RESP_OKAY);
    {m_cnt, m_page} = '0;
    // Let the pulse counter see the edge before it is compared
    @(posedge sys_clk);
    chk(32'h1, 32'(lr_n));
    rd(8'h24, {16'h0, m_ctrl}, RESP_OKAY);
    rd_stat();
    end_of_test();
  end

  // Whole run needs about 450 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end
endmodule
